/* File: common/half_bridge_pkg.sv */
`default_nettype none
package half_bridge_pkg;

  localparam int WORD_BITS = 16;
  localparam int DRIVER_BITS = 12;
  localparam int BIT_COUNT_BITS = 4;

  // Command word bit positions
  localparam int OV_SHUTDOWN_EN_BIT = 15;
  localparam int UL_SHUTDOWN_EN_BIT = 14;
  localparam int OC_SHUTDOWN_EN_BIT = 13;
  localparam int DRIVER_LSB_BIT = 1;
  localparam int STATUS_CLEAR_BIT_POS = 0;

  // Status word bit positions
  localparam int SUPPLY_FAULT_BIT = 15;
  localparam int UNDERLOAD_FAULT_BIT = 14;
  localparam int OVERLOAD_FAULT_BIT = 13;
  localparam int THERMAL_WARNING_BIT = 0;

  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Core clock and the least under-load delay
  localparam int CORE_CLK_PERIOD_PS = 4000;
  localparam int UNDERLOAD_DELAY_US = 200;
  localparam int UNDERLOAD_DELAY_CYCLES =
    (UNDERLOAD_DELAY_US * 1000000 + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;

  // Command word as shifted in; drivers[0] is low side 1, drivers[1] high side 1
  typedef struct packed {
    logic overvoltageShutdownEnable;
    logic underloadShutdownEnable;
    logic overcurrentShutdownEnable;
    logic [DRIVER_BITS-1:0] drivers;
    logic statusClearBit;
  } controlWord_t;

  // Status word as shifted out
  typedef struct packed {
    logic supplyFaultFlag;
    logic underloadFaultFlag;
    logic overloadFaultFlag;
    logic [DRIVER_BITS-1:0] drivers;
    logic thermalWarningFlag;
  } statusWord_t;

  // Conditions reported by the analogue stages, same bit order as drivers
  typedef struct packed {
    logic overvoltage;
    logic undervoltageLockout;
    logic thermalWarning;
    logic [DRIVER_BITS-1:0] underload;
    logic [DRIVER_BITS-1:0] overcurrent;
  } faultIn_t;

endpackage
`default_nettype wire

/* File: logic/sync_bits.sv */
`default_nettype none
module sync_bits #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1_r;

  // First stage feeds only the second one
  always_ff @(posedge clk)
  begin
    stage1_r <= d;
    q <= stage1_r;
  end

endmodule
`default_nettype wire

/* File: logic/half_bridge_spi_control_port.sv */
`default_nettype none
module half_bridge_spi_control_port
  import half_bridge_pkg::*;
#(
  parameter int UNDERLOAD_CYCLES = UNDERLOAD_DELAY_CYCLES,
  parameter int UL_COUNT_BITS = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  output var logic serialOut,
  output var logic serialOutOeN,
  input wire half_bridge_pkg::faultIn_t faultIn,
  output var logic [half_bridge_pkg::DRIVER_BITS-1:0] driverOn,
  output var half_bridge_pkg::controlWord_t controlWord
);
  import half_bridge_pkg::*;

  localparam int SYNC_WIDTH = 3 + $bits(faultIn_t);
  localparam logic [UL_COUNT_BITS-1:0] UL_LIMIT = UL_COUNT_BITS'(UNDERLOAD_CYCLES);

  // Link domain: command shift register on the serial clock itself
  logic [WORD_BITS-1:0] rxShift_r;

  always_ff @(negedge serialClk)
  begin
    if (!chipSelectN)
    begin
      rxShift_r <= {serialIn, rxShift_r[WORD_BITS-1:1]};
    end
  end

  // Core domain view of the pins
  logic [SYNC_WIDTH-1:0] syncIn;
  logic [SYNC_WIDTH-1:0] syncOut;
  logic csSyncN;
  logic sclkSync;
  logic siSync;
  faultIn_t faultSync;

  assign syncIn = {chipSelectN, serialClk, serialIn, faultIn};

  sync_bits #(
    .WIDTH(SYNC_WIDTH)
  ) pinSync (
    .clk(core_clk),
    .d(syncIn),
    .q(syncOut)
  );

  assign csSyncN = syncOut[SYNC_WIDTH-1];
  assign sclkSync = syncOut[SYNC_WIDTH-2];
  assign siSync = syncOut[SYNC_WIDTH-3];
  assign faultSync = syncOut[$bits(faultIn_t)-1:0];

  logic csPrevN_r;
  logic sclkPrev_r;
  logic csFall;
  logic csRise;
  logic sclkRise;
  logic sclkFall;
  logic frameActive;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      csPrevN_r <= 1'b1;
      sclkPrev_r <= 1'b0;
    end
    else
    begin
      csPrevN_r <= csSyncN;
      sclkPrev_r <= sclkSync;
    end
  end

  assign csFall = csPrevN_r & ~csSyncN;
  assign csRise = ~csPrevN_r & csSyncN;
  assign frameActive = ~csSyncN;
  assign sclkRise = frameActive & ~sclkPrev_r & sclkSync;
  assign sclkFall = frameActive & sclkPrev_r & ~sclkSync;

  // Clock counting for frame validity
  logic [BIT_COUNT_BITS-1:0] bitCnt_r;
  logic gotBits_r;
  logic frameOk;

  always_ff @(posedge core_clk)
  begin
    if (rst || csFall)
    begin
      bitCnt_r <= '0;
      gotBits_r <= 1'b0;
    end
    else if (sclkFall)
    begin
      bitCnt_r <= bitCnt_r + 1'b1;
      gotBits_r <= 1'b1;
    end
  end

  // Zero clocks is not a valid frame
  assign frameOk = gotBits_r && (bitCnt_r == '0);

  // Safe to read rxShift_r here: serial clock is idle once chip select is high
  controlWord_t rxWord;
  logic commit;
  logic statusClear;

  assign rxWord = controlWord_t'(rxShift_r);
  assign commit = csRise & frameOk;
  assign statusClear = commit & rxWord.statusClearBit;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      controlWord <= controlWord_t'(CONTROL_RESET);
    end
    else if (commit)
    begin
      controlWord <= rxWord;
    end
  end

  // Under-load timing and per-driver latch-off
  logic [DRIVER_BITS-1:0] ulTrip;
  logic [DRIVER_BITS-1:0] ocHit;
  logic [DRIVER_BITS-1:0] latchedOff_r;

  genvar gi;
  generate
    for (gi = 0; gi < DRIVER_BITS; gi++)
    begin : perDriver
      logic [UL_COUNT_BITS-1:0] ulCnt_r;

      always_ff @(posedge core_clk)
      begin
        if (rst || !driverOn[gi] || !faultSync.underload[gi])
        begin
          ulCnt_r <= '0;
        end
        else if (ulCnt_r != UL_LIMIT)
        begin
          ulCnt_r <= ulCnt_r + 1'b1;
        end
      end

      // Trips once, the cycle the delay runs out
      assign ulTrip[gi] = driverOn[gi] && faultSync.underload[gi] &&
        (ulCnt_r == UL_LIMIT - 1'b1);
      assign ocHit[gi] = driverOn[gi] & faultSync.overcurrent[gi];

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          latchedOff_r[gi] <= 1'b0;
        end
        else if ((controlWord.overcurrentShutdownEnable && ocHit[gi]) ||
          (controlWord.underloadShutdownEnable && ulTrip[gi]))
        begin
          latchedOff_r[gi] <= 1'b1;
        end
        else if (statusClear)
        begin
          latchedOff_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Driver outputs; programmed state is kept through overvoltage
  logic supplyBlock;

  assign supplyBlock = faultSync.undervoltageLockout ||
    (controlWord.overvoltageShutdownEnable && faultSync.overvoltage);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      driverOn <= '0;
    end
    else
    begin
      driverOn <= controlWord.drivers & ~latchedOff_r &
        {DRIVER_BITS{~supplyBlock}};
    end
  end

  // Latched faults: a set in the clear cycle wins
  logic supplyFault_r;
  logic underloadFault_r;
  logic overloadFault_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      supplyFault_r <= 1'b0;
    end
    else if (faultSync.overvoltage || faultSync.undervoltageLockout)
    begin
      supplyFault_r <= 1'b1;
    end
    else if (statusClear)
    begin
      supplyFault_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      underloadFault_r <= 1'b0;
    end
    else if (|ulTrip)
    begin
      underloadFault_r <= 1'b1;
    end
    else if (statusClear)
    begin
      underloadFault_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      overloadFault_r <= 1'b0;
    end
    else if (|ocHit)
    begin
      overloadFault_r <= 1'b1;
    end
    else if (statusClear)
    begin
      overloadFault_r <= 1'b0;
    end
  end

  statusWord_t statusNow;

  always_comb
  begin
    statusNow.supplyFaultFlag = supplyFault_r;
    statusNow.underloadFaultFlag = underloadFault_r;
    statusNow.overloadFaultFlag = overloadFault_r;
    statusNow.drivers = driverOn;
    statusNow.thermalWarningFlag = faultSync.thermalWarning;
  end

  // Output shifter: status first, then the bits received, for chaining
  // Rise k shows bit k-1, so bit 0 survives the first edge and the chain delay is 16
  logic [WORD_BITS-1:0] txShift_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      txShift_r <= STATUS_RESET;
      serialOut <= 1'b0;
    end
    else if (csFall)
    begin
      txShift_r <= WORD_BITS'(statusNow);
      serialOut <= statusNow.thermalWarningFlag;
    end
    else if (sclkFall)
    begin
      txShift_r <= {siSync, txShift_r[WORD_BITS-1:1]};
    end
    else if (sclkRise)
    begin
      serialOut <= txShift_r[0];
    end
  end

  // Enable follows the synchronised chip select, about three core cycles late
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      serialOutOeN <= 1'b1;
    end
    else
    begin
      serialOutOeN <= csSyncN;
    end
  end

endmodule
`default_nettype wire

/* File: sim/half_bridge_spi_sva.sv */
`default_nettype none
module half_bridge_spi_sva
  import half_bridge_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialOut,
  input wire logic serialOutOeN,
  input wire half_bridge_pkg::faultIn_t faultIn,
  input wire logic [half_bridge_pkg::DRIVER_BITS-1:0] driverOn,
  input wire half_bridge_pkg::controlWord_t controlWord
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_OE_RELEASED: assert property (chipSelectN [*6] |-> serialOutOeN)
    else $error("output driven while deselected");
  AST_OE_DRIVEN: assert property (!chipSelectN [*6] |-> !serialOutOeN)
    else $error("output not driven in frame");
  AST_SO_HOLD: assert property ((!chipSelectN && !serialClk) [*8] |-> $stable(serialOut))
    else $error("output moved without a rising clock");
  AST_CW_ON_RISE: assert property ($changed(controlWord) |->
    $past(chipSelectN) && !$past(chipSelectN, 6))
    else $error("command applied away from select rise");
  AST_DRV_SUBSET: assert property ((driverOn & ~$past(controlWord.drivers)) == 12'h000)
    else $error("driver on without command");
  AST_DRV_OFF: assert property ($changed(controlWord.drivers) &&
    controlWord.drivers == 12'h000 |=> driverOn == 12'h000)
    else $error("drivers not off after command");
  AST_OC_LATCH: assert property ((controlWord.overcurrentShutdownEnable &&
    faultIn.overcurrent[0]) [*6] |-> !driverOn[0])
    else $error("overcurrent driver left on");
  AST_OV_OFF: assert property ((controlWord.overvoltageShutdownEnable &&
    faultIn.overvoltage) [*6] |-> driverOn == 12'h000)
    else $error("outputs on during overvoltage");
endmodule
bind half_bridge_spi_control_port half_bridge_spi_sva chk (.core_clk(core_clk), .rst(rst),
  .serialClk(serialClk), .chipSelectN(chipSelectN), .serialOut(serialOut),
  .serialOutOeN(serialOutOeN), .faultIn(faultIn), .driverOn(driverOn),
  .controlWord(controlWord));
`default_nettype wire

/* File: sim/spi_master.sv */
`default_nettype none
module spi_master (
  output var logic serialClk,
  output var logic chipSelectN,
  output var logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOeN
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
  end
  task automatic frame(input logic [31:0] d, input int n, output logic [31:0] rx);
    rx = 32'h0000_0000;
    chipSelectN = 1'b0;
    #100;
    for (int i = 0; i < n; i++)
    begin
      serialIn = d[i];
      #31;
      serialClk = 1'b1;
      #62.5;
      serialClk = 1'b0;
      // Released line reads as the inverse of the design's level
      rx[i] = serialOut ^ serialOutOeN;
      #31.5;
    end
    #100;
    chipSelectN = 1'b1;
    serialIn = ~serialIn;
    #250;
  endtask
endmodule
`default_nettype wire

/* File: sim/test_half_bridge_spi_control_port.sv */
`default_nettype none
module test_half_bridge_spi_control_port;
  import half_bridge_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic serialClk, chipSelectN, serialIn, serialOut, serialOutOeN;
  faultIn_t faultIn = '0;
  logic [DRIVER_BITS-1:0] driverOn;
  controlWord_t controlWord;
  logic [31:0] rx;
  int fail_count = 0;
  int n_checks = 0;
  always #2 core_clk = ~core_clk;
  half_bridge_spi_control_port #(.UNDERLOAD_CYCLES(20)) dut (.core_clk(core_clk), .rst(rst),
    .serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutOeN(serialOutOeN), .faultIn(faultIn),
    .driverOn(driverOn), .controlWord(controlWord));
  spi_master master (.serialClk(serialClk), .chipSelectN(chipSelectN),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutOeN(serialOutOeN));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic [31:0] d, input int n);
    master.frame(d, n, rx);
    #60;
  endtask
  task automatic setf(input faultIn_t f);
    @(posedge core_clk);
    #1;
    faultIn = f;
    #40;
  endtask
  task automatic s_frame;
    check({serialOutOeN, driverOn, controlWord}, 32'h1000_0000);
    setf(27'h100_0000);
    xfer(32'h0000_6AAA, 16);
    check(controlWord, 32'h6AAA);
    check(driverOn, 32'h555);
    check(rx[15:0], 32'h0001);
  endtask
  task automatic s_daisy;
    xfer(32'h5678_1234, 32);
    check(controlWord, 32'h5678);
    check(rx, 32'h1234_0AAB);
    xfer(32'h0000_FFFF, 15);
    check(controlWord, 32'h5678);
  endtask
  task automatic s_overcurrent;
    xfer(32'h2003, 16);
    setf(27'h100_0001);
    check(driverOn, 32'h000);
    setf(27'h100_0000);
    xfer(32'h2002, 16);
    check(rx[15:0], 32'h2001);
    check(driverOn, 32'h000);
    xfer(32'h8003, 16);
    check(driverOn, 32'h001);
  endtask
  task automatic s_overvoltage;
    xfer(32'h8003, 16);
    check(rx[15:0], 32'h0003);
    setf(27'h500_0000);
    check(driverOn, 32'h000);
    setf(27'h100_0000);
    check(driverOn, 32'h001);
    xfer(32'h0002, 16);
    check(rx[15:0], 32'h8003);
  endtask
  task automatic s_underload;
    xfer(32'h4002, 16);
    setf(27'h100_1000);
    #200;
    check(driverOn, 32'h000);
    setf(27'h100_0000);
    xfer(32'h4001, 16);
    check(rx[15:0], 32'hC001);
    check(driverOn, 32'h000);
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    #40;
    s_frame();
    s_daisy();
    s_overcurrent();
    s_overvoltage();
    s_underload();
    end_sim();
  end
endmodule
`default_nettype wire
